// File: adc_select_map.vh
// register offsets, field positions and reset values for the converter
// input-select and scan-select block; definitions only
`ifndef ADC_SELECT_MAP_VH
`define ADC_SELECT_MAP_VH

`define OFF_INPUT_SELECT_CTRL 8'h00
`define OFF_SCAN_SELECT_HIGH  8'h04
`define OFF_SCAN_SELECT_LOW   8'h08

`define RST_INPUT_SELECT_CTRL 16'h0000
`define RST_SCAN_SELECT_HIGH  16'h0000
`define RST_SCAN_SELECT_LOW   16'h0000

// writable bits of the high scan word: 14..10 and 7..0
`define SCAN_HIGH_MASK        16'h7CFF

`define NEG_B_MSB 15
`define NEG_B_LSB 13
`define POS_B_MSB 12
`define POS_B_LSB 8
`define NEG_A_MSB 7
`define NEG_A_LSB 5
`define POS_A_MSB 4
`define POS_A_LSB 0

// positive-select codes
`define POS_HIGHEST_INPUT 5'h15
`define POS_FLOAT_TEMP    5'h16
`define POS_FLOAT_ALL     5'h17
`define POS_BAND_GAP      5'h1A
`define POS_LOWER_GUARD   5'h1B
`define POS_UNUSED        5'h1F

// negative-select codes
`define NEG_GROUND        3'h0

`endif

// File: adc_mux_decode.v
// decodes one negative/positive select pair into routing; negative one-hot, positive at most two outputs (10110)
// assumes the caller holds the codes stable in registers
`include "adc_select_map.vh"
`default_nettype none

module adc_mux_decode #(
    parameter INPUTS = 22
)(
    // select codes
    input wire [2:0] neg_select,
    input wire [4:0] pos_select,
    // routing
    output reg neg_ground,
    output reg [6:0] neg_input,
    output reg [INPUTS-1:0] pos_input,
    output reg pos_float,
    output reg pos_temp,
    output reg pos_band_gap,
    output reg pos_lower_guard
);

    integer i;

    always @*
    begin
        neg_ground = (neg_select == `NEG_GROUND); // see [RULE1]
        neg_input = 7'h00;
        if (neg_select != `NEG_GROUND)
        begin
            neg_input[neg_select - 3'h1] = 1'b1; // see [RULE1]
        end
        pos_input = {INPUTS{1'b0}};
        for (i = 0; i < INPUTS; i = i + 1)
        begin
            if ((pos_select == i[4:0]) &&
                (pos_select <= `POS_HIGHEST_INPUT))
            begin
                pos_input[i] = 1'b1; // see [RULE4]
            end
        end
        // both floating codes leave every input open
        pos_float = (pos_select == `POS_FLOAT_ALL) ||
                    (pos_select == `POS_FLOAT_TEMP); // see [RULE3]
        pos_temp = (pos_select == `POS_FLOAT_TEMP); // see [RULE3]
        pos_band_gap = (pos_select == `POS_BAND_GAP); // see [RULE6]
        // unused code 11111 connects nothing
        pos_lower_guard = (pos_select == `POS_LOWER_GUARD); // see [RULE6]
    end

endmodule

`default_nettype wire

// File: adc_input_and_scan_select.v
// converter input-select and scan-select registers behind an AHB-Lite slave
// assumes single word transfers from one master; hready from hreadyout
`include "adc_select_map.vh"
`default_nettype none

// Contract
// [RULE1] bits 15:13 pick sample B negative input
// [RULE2] bits 12:8 pick sample B positive source
// [RULE3] codes 10111/10110 float inputs; 10110 adds temperature
// [RULE4] codes up to 10101 route analog inputs
// [RULE5] code 11111 unused, no defined connection
// [RULE6] 11010 band gap, 11011 lower guardband
// [RULE7] low scan word bits include inputs 15:0
// [RULE8] high scan word channels 30:26, 23:16; rest zero
// [RULE9] unimplemented scan bits read back zero
// [RULE10] low byte mirrors fields for multiplexer A
module adc_input_and_scan_select #(
    parameter INPUTS = 22
)(
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // sample b routing
    output wire b_neg_ground,
    output wire [6:0] b_neg_input,
    output wire [INPUTS-1:0] b_pos_input,
    output wire b_pos_float,
    output wire b_pos_temp,
    output wire b_pos_band_gap,
    output wire b_pos_lower_guard,
    // sample a routing
    output wire a_neg_ground,
    output wire [6:0] a_neg_input,
    output wire [INPUTS-1:0] a_pos_input,
    output wire a_pos_float,
    output wire a_pos_temp,
    output wire a_pos_band_gap,
    output wire a_pos_lower_guard,
    // scan include set, channel n at bit n
    output wire [31:0] scan_include_bits
);

    reg [15:0] input_select_ctrl;
    reg [15:0] scan_select_high;
    reg [15:0] scan_select_low;
    reg wr_pending;
    reg [7:0] wr_addr;
    reg [31:0] next_rdata;

    wire take = hsel && hready && htrans[1];
    // write still in its data phase to the address now read
    wire fwd = wr_pending && (wr_addr == haddr);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // address phase captured, write data lands one cycle later
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pending <= take && hwrite;
            if (take)
            begin
                wr_addr <= haddr;
            end
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            input_select_ctrl <= `RST_INPUT_SELECT_CTRL;
            scan_select_high <= `RST_SCAN_SELECT_HIGH;
            scan_select_low <= `RST_SCAN_SELECT_LOW;
        end
        else if (wr_pending)
        begin
            case (wr_addr)
                `OFF_INPUT_SELECT_CTRL:
                begin
                    // code 11111 is stored as written; decode gives it nothing
                    input_select_ctrl <= hwdata[15:0]; // see [RULE5]
                end
                `OFF_SCAN_SELECT_HIGH:
                begin
                    scan_select_high <=
                        hwdata[15:0] & `SCAN_HIGH_MASK; // see [RULE8]
                end
                `OFF_SCAN_SELECT_LOW:
                begin
                    scan_select_low <= hwdata[15:0]; // see [RULE7]
                end
                default:
                begin
                    scan_select_low <= scan_select_low;
                end
            endcase
        end
    end

    // read data registered at the address phase, so it stands in data phase;
    // a write not yet landed is forwarded so a read right after the write sees it
    always @*
    begin
        case (haddr)
            `OFF_INPUT_SELECT_CTRL:
                next_rdata = fwd ? {16'h0000, hwdata[15:0]}
                                 : {16'h0000, input_select_ctrl};
            `OFF_SCAN_SELECT_HIGH:
                next_rdata = fwd ?
                    {16'h0000, hwdata[15:0] & `SCAN_HIGH_MASK} // see [RULE9]
                    : {16'h0000, scan_select_high}; // see [RULE9]
            `OFF_SCAN_SELECT_LOW:
                next_rdata = fwd ? {16'h0000, hwdata[15:0]}
                                 : {16'h0000, scan_select_low};
            default:
                next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (take && !hwrite)
        begin
            hrdata <= next_rdata;
        end
    end

    // channels 24, 25 and 31 are absent and stay zero
    assign scan_include_bits = {1'b0, scan_select_high[14:10], 2'b00,
                                scan_select_high[7:0],
                                scan_select_low}; // see [RULE8] [RULE7]

    adc_mux_decode #(
        .INPUTS(INPUTS)
    ) decode_b (
        .neg_select(input_select_ctrl[`NEG_B_MSB:`NEG_B_LSB]), // see [RULE1]
        .pos_select(input_select_ctrl[`POS_B_MSB:`POS_B_LSB]), // see [RULE2]
        .neg_ground(b_neg_ground),
        .neg_input(b_neg_input),
        .pos_input(b_pos_input),
        .pos_float(b_pos_float),
        .pos_temp(b_pos_temp),
        .pos_band_gap(b_pos_band_gap),
        .pos_lower_guard(b_pos_lower_guard)
    );

    adc_mux_decode #(
        .INPUTS(INPUTS)
    ) decode_a (
        .neg_select(input_select_ctrl[`NEG_A_MSB:`NEG_A_LSB]), // see [RULE10]
        .pos_select(input_select_ctrl[`POS_A_MSB:`POS_A_LSB]), // see [RULE10]
        .neg_ground(a_neg_ground),
        .neg_input(a_neg_input),
        .pos_input(a_pos_input),
        .pos_float(a_pos_float),
        .pos_temp(a_pos_temp),
        .pos_band_gap(a_pos_band_gap),
        .pos_lower_guard(a_pos_lower_guard)
    );

endmodule

`default_nettype wire

// File: adc_input_and_scan_select_monitor.sv
// checker for the converter select block, sees top ports only
// assumes hready is fed from hreadyout
`include "adc_select_map.vh"
`default_nettype none
module adc_select_monitor #(parameter INPUTS = 22)(
    // bus
    input wire logic hclk, hresetn, hsel, hwrite, hreadyout, hresp,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [31:0] hwdata, scan_include_bits,
    // routing
    input wire logic b_neg_ground, a_neg_ground, b_pos_float,
    input wire logic b_pos_temp, b_pos_band_gap,
    input wire logic [6:0] b_neg_input, a_neg_input,
    input wire logic [INPUTS-1:0] b_pos_input
);
    logic low_wr;
    // marks the data phase of a write to the low scan word
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            low_wr <= 1'h0;
        else
            low_wr <= hsel && hreadyout && htrans[1] && hwrite
                && haddr == `OFF_SCAN_SELECT_LOW;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("wait state or error response");
    chk_scan_gaps: assert property (
        scan_include_bits[31] == 1'h0 && scan_include_bits[25:24] == 2'h0)
        else $error("absent scan channel set");
    chk_scan_write: assert property (
        low_wr |=> scan_include_bits[15:0] == $past(hwdata[15:0]))
        else $error("low scan word write lost");
    chk_b_neg_one: assert property (
        $onehot({b_neg_ground, b_neg_input}))
        else $error("sample b negative not one-hot");
    chk_a_neg_one: assert property (
        $onehot({a_neg_ground, a_neg_input}))
        else $error("sample a negative not one-hot");
    chk_temp_floats: assert property (
        b_pos_temp |-> b_pos_float && b_pos_input == '0)
        else $error("temperature path not floating");
    chk_band_gap: assert property (
        b_pos_band_gap |-> !b_pos_float && !b_pos_temp && b_pos_input == '0)
        else $error("band gap shares the input");
    chk_pos_route: assert property (
        |b_pos_input |-> $onehot(b_pos_input) && !b_pos_float)
        else $error("positive input routing not one-hot");
endmodule
bind adc_input_and_scan_select adc_select_monitor #(.INPUTS(INPUTS))
    u_adc_select_monitor (.hclk, .hresetn, .hsel, .hwrite, .hreadyout,
    .hresp, .haddr, .htrans, .hwdata, .scan_include_bits, .b_neg_ground,
    .a_neg_ground, .b_pos_float, .b_pos_temp, .b_pos_band_gap,
    .b_neg_input, .a_neg_input, .b_pos_input);
`default_nettype wire

// File: adc_input_and_scan_select_tb.sv
// self-checking bench for the converter select block
// assumes design, map header and bound checker are compiled alongside
`include "adc_select_map.vh"
`default_nettype none
module adc_input_and_scan_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic rd_dp = 1'h0;
    logic [7:0] haddr = 8'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, seed = 32'hF053CDCB, w, sh;
    logic [31:0] exp_q[$];
    wire hreadyout, hresp, b_neg_ground, b_pos_float, b_pos_temp;
    wire hready = hreadyout;
    wire b_pos_band_gap, b_pos_lower_guard, a_neg_ground, a_pos_float;
    wire a_pos_temp, a_pos_band_gap, a_pos_lower_guard;
    wire [6:0] b_neg_input, a_neg_input;
    wire [21:0] b_pos_input, a_pos_input;
    wire [31:0] hrdata, scan_include_bits;
    int error_cnt = 0, comparisons = 0, cyc = 0;
    adc_input_and_scan_select u_adc_input_and_scan_select (.hclk, .hresetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .b_neg_ground, .b_neg_input,
        .b_pos_input, .b_pos_float, .b_pos_temp, .b_pos_band_gap,
        .b_pos_lower_guard, .a_neg_ground, .a_neg_input, .a_pos_input,
        .a_pos_float, .a_pos_temp, .a_pos_band_gap, .a_pos_lower_guard,
        .scan_include_bits);
    initial
        forever #4 hclk = ~hclk;
    // wide enough for the routing bits next to the scan word
    task automatic check(input string what, input logic [39:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] neg_exp(input logic [2:0] n);
        return n == 3'h0 ? 8'h80 : 8'h1 << (n - 3'h1);
    endfunction
    function automatic logic [25:0] pos_exp(input logic [4:0] c);
        pos_exp = 26'h0;
        if (c < 5'h16)
            pos_exp[c] = 1'h1;
        pos_exp[22] = c == 5'h16 || c == 5'h17;
        pos_exp[23] = c == 5'h16;
        pos_exp[24] = c == 5'h1A;
        pos_exp[25] = c == 5'h1B;
    endfunction
    // read: d is the expected word, compared by the watcher below
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        if (!wr)
            exp_q.push_back(d);
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        rd_dp <= !wr;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hready !== 1'h1);
        rd_dp <= 1'h0;
    endtask
    always @(posedge hclk)
        if (rd_dp)
            check("read data", hrdata, exp_q.pop_front());
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            end_of_test;
        end
    end
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        check("reset route", {b_neg_ground, b_pos_input[0], a_neg_ground,
            a_pos_input[0], scan_include_bits}, 36'hF00000000);
        for (int i = 0; i < 3; i++)
            xfer(1'h0, 8'(i * 4), 32'h0);
        $display("reset test done");
        // every positive code but the unused top one
        for (int c = 0; c < 31; c++)
        begin
            seed = lfsr(seed);
            w = {16'h0, seed[31:29], 5'(c), seed[7:5], 5'(30 - c)};
            xfer(1'h1, `OFF_INPUT_SELECT_CTRL, w);
            @(negedge hclk);
            check("b pos", {b_pos_lower_guard, b_pos_band_gap,
                b_pos_temp, b_pos_float, b_pos_input}, pos_exp(w[12:8]));
            check("a pos", {a_pos_lower_guard, a_pos_band_gap,
                a_pos_temp, a_pos_float, a_pos_input}, pos_exp(w[4:0]));
            check("b neg", {b_neg_ground, b_neg_input},
                neg_exp(w[15:13]));
            check("a neg", {a_neg_ground, a_neg_input},
                neg_exp(w[7:5]));
            xfer(1'h0, `OFF_INPUT_SELECT_CTRL, w);
        end
        $display("routing test done");
        for (int i = 0; i < 5; i++)
        begin
            seed = lfsr(seed);
            sh = i == 0 ? 32'hFFFF : seed;
            w = i == 0 ? 32'hFFFF : seed[15:0];
            xfer(1'h1, `OFF_SCAN_SELECT_HIGH, sh);
            xfer(1'h1, `OFF_SCAN_SELECT_LOW, w);
            xfer(1'h0, `OFF_SCAN_SELECT_HIGH, sh & 32'h7CFF);
            @(negedge hclk);
            check("scan set", scan_include_bits,
                {1'h0, sh[14:10], 2'h0, sh[7:0], w[15:0]});
        end
        // unmapped place: write dropped, read zero, low scan word kept
        xfer(1'h1, 8'h0C, 32'h5A5A);
        xfer(1'h0, 8'h0C, 32'h0);
        xfer(1'h0, `OFF_SCAN_SELECT_LOW, w);
        @(negedge hclk);
        $display("scan test done");
        end_of_test;
    end
endmodule
`default_nettype wire
